// file: rtl/itf_pkg.sv
package itf_pkg;

    // ------------------------------------------------------------
    // fifo geometry
    // ------------------------------------------------------------
    localparam int       FIFO_DEPTH = 16;
    localparam int       FIFO_AW    = 4;
    localparam int       BYTE_W     = 8;
    localparam logic [4:0] DEPTH_CNT = 5'h10;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TXDATA = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RAW    = 8'h0C;
    localparam logic [7:0] OFS_CLR    = 8'h10;
    localparam logic [7:0] OFS_EN     = 8'h14;
    localparam logic [7:0] OFS_LEVEL  = 8'h18;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_DMA   = 0;
    localparam int CTRL_BS_LO = 1;
    localparam int CTRL_TH_LO = 4;
    localparam int CTRL_MW    = 8;
    localparam int SR_ST_LO   = 2;
    localparam int SR_CA_LO   = 4;
    localparam int SR_LEN_LO  = 9;
    localparam logic [3:0]  TH_RST   = 4'h4;
    localparam logic [7:0]  TX_RST   = 8'h00;
    localparam logic [10:0] LEN_MAX  = 11'h7FF;

    // interrupt bit positions
    localparam int IRQ_N     = 4;
    localparam int IRQ_RREQ  = 0;
    localparam int IRQ_REMP  = 1;
    localparam int IRQ_DONE  = 2;
    localparam int IRQ_NEMP  = 3;

    // operation, status and cause codes
    localparam logic [1:0] OP_MW      = 2'h0;
    localparam logic [1:0] OP_RFS     = 2'h3;
    localparam logic [1:0] ST_NOP     = 2'h0;
    localparam logic [1:0] ST_ONGOING = 2'h1;
    localparam logic [1:0] ST_OK      = 2'h2;
    localparam logic [1:0] ST_ABORT   = 2'h3;
    localparam logic [2:0] CA_NONE    = 3'h0;
    localparam logic [2:0] CA_STOP    = 3'h5;

    // link engine states
    typedef enum logic [2:0] {
        ITF_IDLE, ITF_LOAD, ITF_BIT_HI, ITF_BIT_LO, ITF_ACK_HI, ITF_ACK_LO
    } itf_link_t;

endpackage : itf_pkg

// file: rtl/itf_mem.sv
`timescale 1ns/1ns
`default_nettype none

module itf_mem (
    input  wire logic                        clk,
    input  wire logic                        wr_en,
    input  wire logic [itf_pkg::FIFO_AW-1:0] wr_addr,
    input  wire logic [itf_pkg::BYTE_W-1:0]  wr_data,
    input  wire logic [itf_pkg::FIFO_AW-1:0] rd_addr,
    output logic      [itf_pkg::BYTE_W-1:0]  rd_data
);

    // ------------------------------------------------------------
    // storage, read data registered
    // ------------------------------------------------------------
    logic [itf_pkg::BYTE_W-1:0] mem_r [itf_pkg::FIFO_DEPTH];

    // write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // read port
    always_ff @(posedge clk) begin
        rd_data <= mem_r[rd_addr];
    end

endmodule : itf_mem
`default_nettype wire

// file: rtl/itf_link.sv
`timescale 1ns/1ns
`default_nettype none

module itf_link (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       start,
    input  wire logic                       scl_s,
    input  wire logic                       sda_s,
    input  wire logic                       byte_valid,
    input  wire logic [itf_pkg::BYTE_W-1:0] byte_data,
    output logic                            byte_take,
    output logic                            stretch,
    output logic                            sda_oe,
    output logic                            nack_p,
    output logic                            stop_p,
    output logic                            busy
);

    // ------------------------------------------------------------
    // edge detection on synchronised lines
    // ------------------------------------------------------------
    logic                       scl_d_r;
    logic                       sda_d_r;
    logic                       sda_low_r;
    logic [itf_pkg::BYTE_W-1:0] sh_r;
    logic [2:0]                 bit_r;
    itf_pkg::itf_link_t         st_r;

    wire scl_rise = scl_s && !scl_d_r;
    wire scl_fall = !scl_s && scl_d_r;
    wire stop_det = scl_s && scl_d_r && sda_s && !sda_d_r;
    wire in_load  = (st_r == itf_pkg::ITF_LOAD);

    // handshake outputs
    assign byte_take = in_load && byte_valid;
    assign stretch   = in_load && !byte_valid;
    assign nack_p    = (st_r == itf_pkg::ITF_ACK_HI) && scl_rise && sda_s;
    assign stop_p    = busy && stop_det;
    assign busy      = (st_r != itf_pkg::ITF_IDLE);
    assign sda_oe    = sda_low_r;

    // line history
    always_ff @(posedge clk) begin
        scl_d_r <= scl_s;
        sda_d_r <= sda_s;
    end

    // ------------------------------------------------------------
    // slave transmitter, lsb first
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset || stop_p) begin
            st_r      <= itf_pkg::ITF_IDLE;
            sda_low_r <= 1'b0;
            sh_r      <= 8'h00;
            bit_r     <= 3'h0;
        end else begin
            case (st_r)
                itf_pkg::ITF_IDLE: begin
                    if (start) st_r <= itf_pkg::ITF_LOAD;
                end
                itf_pkg::ITF_LOAD: begin
                    if (byte_valid) begin
                        sh_r      <= byte_data;
                        sda_low_r <= !byte_data[0];
                        bit_r     <= 3'h0;
                        st_r      <= itf_pkg::ITF_BIT_HI;
                    end
                end
                itf_pkg::ITF_BIT_HI: begin
                    if (scl_rise) st_r <= itf_pkg::ITF_BIT_LO;
                end
                itf_pkg::ITF_BIT_LO: begin
                    if (scl_fall && bit_r == 3'h7) begin
                        sda_low_r <= 1'b0;               // release for ack
                        st_r      <= itf_pkg::ITF_ACK_HI;
                    end else if (scl_fall) begin
                        sda_low_r <= !sh_r[1];
                        sh_r      <= sh_r >> 1;
                        bit_r     <= bit_r + 3'h1;
                        st_r      <= itf_pkg::ITF_BIT_HI;
                    end
                end
                itf_pkg::ITF_ACK_HI: begin
                    if (nack_p) st_r <= itf_pkg::ITF_IDLE;
                    else if (scl_rise) st_r <= itf_pkg::ITF_ACK_LO;
                end
                itf_pkg::ITF_ACK_LO: begin
                    if (scl_fall) st_r <= itf_pkg::ITF_LOAD;
                end
                default: st_r <= itf_pkg::ITF_IDLE;
            endcase
        end
    end

endmodule : itf_link
`default_nettype wire

// file: rtl/itf_tx_feed.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - each write of the data register low byte pushes one fifo byte unless the fifo is full or being flushed
// - bit 0 of every byte goes onto the bus first
// - a master write may only begin once the fifo holds data
// - on slave-read addressing flush the fifo, then raise the request flag
// - fifo empty while master still reads raises the empty request flag
// - slave transmitter holds clock low while no byte is available
// - slave read end raises done flag and records outcome in status
// - in cpu mode the nearly-empty flag paces software refills
// - dma mode asks single or burst by free entries and burst size
// - dma mode ends a nacked read with one dummy last request
// - master write may exceed fifo depth, software keeps refilling
// - slave read past the countable length reports length zero
module itf_tx_feed (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_oe,
    output logic             sda_oe,
    input  wire logic        rfs_addressed,
    input  wire logic        mw_take,
    input  wire logic        mw_done,
    output logic             mw_go,
    output logic      [7:0]  mw_byte,
    output logic             dma_single_req,
    output logic             dma_burst_req,
    output logic             dma_last,
    output logic             irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0]                  scl_sy_r;
    logic [1:0]                  sda_sy_r;
    logic [itf_pkg::FIFO_AW-1:0] wp_r;
    logic [itf_pkg::FIFO_AW-1:0] rp_r;
    logic [4:0]                  cnt_r;
    logic                        settle_r;
    logic [7:0]                  txd_r;
    logic                        dma_en_r;
    logic [1:0]                  bsz_r;
    logic [3:0]                  th_r;
    logic                        mw_pend_r;
    logic                        flush_d_r;
    logic                        rfs_act_r;
    logic [11:0]                 len_r;
    logic [1:0]                  op_r;
    logic [1:0]                  st_r;
    logic [2:0]                  ca_r;
    logic [itf_pkg::IRQ_N-1:0]   raw_r;
    logic [itf_pkg::IRQ_N-1:0]   en_r;
    logic [itf_pkg::IRQ_N-1:0]   ev;
    logic [7:0]                  fifo_q;
    logic                        take;
    logic                        stretch;
    logic                        nack_p;
    logic                        stop_p;
    logic                        busy;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire wr_tx   = wr && (addr == itf_pkg::OFS_TXDATA);
    wire wr_ctrl = wr && (addr == itf_pkg::OFS_CTRL);
    wire wr_clr  = wr && (addr == itf_pkg::OFS_CLR);
    wire wr_en   = wr && (addr == itf_pkg::OFS_EN);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        scl_sy_r <= {scl_sy_r[0], scl_in};
        sda_sy_r <= {sda_sy_r[0], sda_in};
    end

    // ------------------------------------------------------------
    // fifo control
    // ------------------------------------------------------------
    wire flush     = rfs_addressed;
    wire full      = (cnt_r == itf_pkg::DEPTH_CNT);
    wire empty     = (cnt_r == 5'h00);
    wire push      = wr_tx && !full && !flush;
    wire q_valid   = !empty && !settle_r;
    wire pop_mw    = mw_take && mw_go && q_valid;
    wire pop       = (take || pop_mw) && !flush;
    wire [4:0] cnt_nxt = cnt_r + {4'h0, push} - {4'h0, pop};
    wire [4:0] free    = itf_pkg::DEPTH_CNT - cnt_r;

    // pointers and level
    always_ff @(posedge clk) begin
        if (reset || flush) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= 5'h00;
        end else begin
            if (push) wp_r <= wp_r + 4'h1;
            if (pop) rp_r <= rp_r + 4'h1;
            cnt_r <= cnt_nxt;
        end
    end

    // read data is stale for one cycle after any pointer movement
    always_ff @(posedge clk) begin
        if (reset) settle_r <= 1'b1;
        else settle_r <= push || pop || flush;
    end

    itf_mem u_mem (
        .clk     (clk),
        .wr_en   (push),
        .wr_addr (wp_r),
        .wr_data (wdata[7:0]),
        .rd_addr (rp_r),
        .rd_data (fifo_q)
    );

    assign mw_byte = fifo_q;

    // ------------------------------------------------------------
    // slave transmitter on the link
    // ------------------------------------------------------------
    itf_link u_link (
        .clk        (clk),
        .reset      (reset),
        .start      (flush_d_r),
        .scl_s      (scl_sy_r[1]),
        .sda_s      (sda_sy_r[1]),
        .byte_valid (q_valid && rfs_act_r),
        .byte_data  (fifo_q),
        .byte_take  (take),
        .stretch    (stretch),
        .sda_oe     (sda_oe),
        .nack_p     (nack_p),
        .stop_p     (stop_p),
        .busy       (busy)
    );

    assign scl_oe = stretch;

    wire rfs_end = rfs_act_r && (nack_p || stop_p);

    // ------------------------------------------------------------
    // control register and master write gate
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            txd_r    <= itf_pkg::TX_RST;
            dma_en_r <= 1'b0;
            bsz_r    <= 2'h0;
            th_r     <= itf_pkg::TH_RST;
        end else begin
            if (wr_tx) txd_r <= wdata[7:0];
            if (wr_ctrl) begin
                dma_en_r <= wdata[itf_pkg::CTRL_DMA];
                bsz_r    <= wdata[itf_pkg::CTRL_BS_LO +: 2];
                th_r     <= wdata[itf_pkg::CTRL_TH_LO +: 4];
            end
        end
    end

    // pending master write waits for payload before going
    always_ff @(posedge clk) begin
        if (reset || mw_done) mw_pend_r <= 1'b0;
        else if (wr_ctrl && wdata[itf_pkg::CTRL_MW]) mw_pend_r <= 1'b1;
    end

    assign mw_go = mw_pend_r && (!empty || op_r == itf_pkg::OP_MW
                   && st_r == itf_pkg::ST_ONGOING);

    // ------------------------------------------------------------
    // slave read sequencing: flush first, flag and start next cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            flush_d_r <= 1'b0;
            rfs_act_r <= 1'b0;
        end else begin
            flush_d_r <= flush;
            if (flush) rfs_act_r <= 1'b1;
            else if (rfs_end || (rfs_act_r && !busy && !flush_d_r))
                rfs_act_r <= 1'b0;
        end
    end

    // byte counter, overflow past the countable length kept in bit 11
    always_ff @(posedge clk) begin
        if (reset || flush || (mw_go && !mw_pend_r)) len_r <= 12'h000;
        else if ((take || pop_mw) && !len_r[11]) len_r <= len_r + 12'h001;
    end

    wire [10:0] len_rep = len_r[11] ? 11'h000 : len_r[10:0];

    // ------------------------------------------------------------
    // operation status
    // ------------------------------------------------------------
    wire mw_begin = mw_go && !(op_r == itf_pkg::OP_MW
                    && st_r == itf_pkg::ST_ONGOING) && !rfs_act_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            op_r <= itf_pkg::OP_MW;
            st_r <= itf_pkg::ST_NOP;
            ca_r <= itf_pkg::CA_NONE;
        end else if (flush) begin
            op_r <= itf_pkg::OP_RFS;
            st_r <= itf_pkg::ST_ONGOING;
            ca_r <= itf_pkg::CA_NONE;
        end else if (rfs_end) begin
            st_r <= nack_p ? itf_pkg::ST_OK : itf_pkg::ST_ABORT;
            ca_r <= nack_p ? itf_pkg::CA_NONE : itf_pkg::CA_STOP;
        end else if (mw_begin) begin
            op_r <= itf_pkg::OP_MW;
            st_r <= itf_pkg::ST_ONGOING;
            ca_r <= itf_pkg::CA_NONE;
        end else if (mw_done && op_r == itf_pkg::OP_MW) begin
            st_r <= itf_pkg::ST_OK;
        end
    end

    // ------------------------------------------------------------
    // interrupt events, set wins over clear
    // ------------------------------------------------------------
    assign ev[itf_pkg::IRQ_RREQ] = flush_d_r;
    assign ev[itf_pkg::IRQ_REMP] = rfs_act_r && stretch && len_r != 0;
    assign ev[itf_pkg::IRQ_DONE] = rfs_end;
    assign ev[itf_pkg::IRQ_NEMP] = !dma_en_r && cnt_r <= {1'b0, th_r};

    always_ff @(posedge clk) begin
        if (reset) raw_r <= '0;
        else raw_r <= ev | (raw_r & ~(wr_clr ? wdata[3:0] : 4'h0));
    end

    always_ff @(posedge clk) begin
        if (reset) en_r <= '0;
        else if (wr_en) en_r <= wdata[3:0];
    end

    assign irq = |(raw_r & en_r);

    // ------------------------------------------------------------
    // dma requests, burst when room for a whole burst
    // ------------------------------------------------------------
    wire [4:0] bsz_n = (bsz_r == 2'h0) ? 5'h01 :
                       (bsz_r == 2'h1) ? 5'h04 :
                       (bsz_r == 2'h2) ? 5'h08 : 5'h10;
    wire dma_on  = dma_en_r && (rfs_act_r || mw_pend_r) && !flush
                   && !flush_d_r;
    wire want_b  = free >= bsz_n && bsz_r != 2'h0;
    wire last_ev = dma_en_r && rfs_act_r && nack_p;

    always_ff @(posedge clk) begin
        if (reset) begin
            dma_single_req <= 1'b0;
            dma_burst_req  <= 1'b0;
            dma_last       <= 1'b0;
        end else begin
            dma_burst_req  <= (dma_on && want_b) || (last_ev && want_b);
            dma_single_req <= (dma_on && !want_b && free != 0)
                              || (last_ev && !want_b);
            dma_last       <= last_ev;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    wire [31:0] sr_word = {12'h000, len_rep, 2'h0, ca_r, st_r, op_r};
    wire [31:0] rd_mux  =
        (addr == itf_pkg::OFS_TXDATA) ? {24'h000000, txd_r} :
        (addr == itf_pkg::OFS_CTRL)   ? {23'h0, mw_pend_r, th_r,
                                         1'b0, bsz_r, dma_en_r} :
        (addr == itf_pkg::OFS_STATUS) ? sr_word :
        (addr == itf_pkg::OFS_RAW)    ? {28'h0, raw_r} :
        (addr == itf_pkg::OFS_EN)     ? {28'h0, en_r} :
        (addr == itf_pkg::OFS_LEVEL)  ? {27'h0, cnt_r} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (reset) rdata <= 32'h00000000;
        else if (rd) rdata <= rd_mux;
        else rdata <= 32'h00000000;
    end

endmodule : itf_tx_feed
`default_nettype wire

// file: verification/itf_tx_feed_assertions.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------
// port checker of the transmit feed
// ----------------
module itf_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        scl_oe,
    input wire logic        rfs_addressed,
    input wire logic        mw_done,
    input wire logic        mw_go,
    input wire logic        dma_single_req,
    input wire logic        dma_burst_req,
    input wire logic        dma_last,
    input wire logic        irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // read port, stretch, dma, interrupt and master write relations
    property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_unmap; rd && addr > 8'h18 |=> rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_readback;
        (wr && addr == 8'h00 && !rfs_addressed) ##1 !wr ##1
        (rd && addr == 8'h00) |=> rdata[7:0] == $past(wdata[7:0], 3);
    endproperty
    a_readback: assert property (p_readback) else $error("data back");
    property p_stretch; rfs_addressed |=> ##1 scl_oe; endproperty
    a_stretch: assert property (p_stretch) else $error("no stretch");
    property p_flush; rfs_addressed |=> !dma_single_req && !dma_burst_req;
    endproperty
    a_flush: assert property (p_flush) else $error("request on flush");
    property p_one_req; !(dma_single_req && dma_burst_req); endproperty
    a_one_req: assert property (p_one_req) else $error("two requests");
    property p_last; dma_last |=> !dma_last; endproperty
    a_last: assert property (p_last) else $error("last too long");
    property p_mask; wr && addr == 8'h14 && wdata[3:0] == 4'h0 |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_mw_end; mw_done |=> !mw_go; endproperty
    a_mw_end: assert property (p_mw_end) else $error("go after done");
    property p_raw; rd && addr == 8'h0C |=> rdata[31:4] == 28'h0; endproperty
    a_raw: assert property (p_raw) else $error("raw bits high");
endmodule : itf_chk

bind itf_tx_feed itf_chk i_chk (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scl_oe(scl_oe), .mw_go(mw_go),
    .rfs_addressed(rfs_addressed), .mw_done(mw_done), .irq(irq),
    .dma_single_req(dma_single_req), .dma_burst_req(dma_burst_req),
    .dma_last(dma_last)
);

`default_nettype wire

// file: verification/itf_bus_master.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------
// external master reading bytes from the slave
// ----------------
module itf_bus_master (
    input  wire logic clk,
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    logic [7:0] got_q[$];

    // both lines released, clock idles high
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // clock held low as after the address phase
    task automatic hold;
        @(posedge clk);
        scl_low <= 1'b1;
    endtask : hold

    // one clock pulse: waits out stretching, samples data while high
    task automatic pulse(input int slow, output logic b);
        int n;
        n = 0;
        @(posedge clk);
        scl_low <= 1'b0;
        while (scl_line !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        b = sda_line;
        repeat (4) @(posedge clk);
        scl_low <= 1'b1;
        repeat (8 + slow) @(posedge clk);
    endtask : pulse

    // reads n bytes, acknowledging all but the last
    task automatic read_frame(input int nbytes, input int slow);
        logic [7:0] b;
        logic       a;
        for (int i = 0; i < nbytes; i++) begin
            for (int k = 0; k < 8; k++) pulse(slow, b[k]);
            sda_low <= (i < nbytes - 1);
            pulse(slow, a);
            sda_low <= 1'b0;
            got_q.push_back(b);
        end
        @(posedge clk);
        scl_low <= 1'b0;
    endtask : read_frame
endmodule : itf_bus_master

`default_nettype wire

// file: verification/itf_tx_feed_bench.sv
`timescale 1ns/1ns
`default_nettype none

module itf_tx_feed_bench;
    logic        clk, reset, wr, rd, rfs_addressed, mw_take, mw_done;
    logic        scl_oe, sda_oe, mw_go, dma_single_req, dma_burst_req;
    logic        dma_last, irq, scl_low, sda_low, last_seen;
    logic [7:0]  addr, mw_byte;
    logic [31:0] wdata, rdata;
    int          num_errors, tests_run, cycles;
    wire logic   scl_line = !(scl_oe || scl_low);
    wire logic   sda_line = !(sda_oe || sda_low);

    // ----------------
    // design, bus master, clock and hang guard
    // ----------------
    itf_tx_feed i_dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .scl_in(scl_line), .sda_in(sda_line),
        .scl_oe(scl_oe), .sda_oe(sda_oe), .rfs_addressed(rfs_addressed),
        .mw_take(mw_take), .mw_done(mw_done), .mw_go(mw_go),
        .mw_byte(mw_byte), .dma_single_req(dma_single_req),
        .dma_burst_req(dma_burst_req), .dma_last(dma_last), .irq(irq)
    );
    itf_bus_master i_m (
        .clk(clk), .scl_line(scl_line), .sda_line(sda_line),
        .scl_low(scl_low), .sda_low(sda_low)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (dma_last === 1'b1) last_seen <= 1'b1;
        if (cycles == 60000) begin
            num_errors++;
            test_done;
        end
    end

    // ----------------
    // bus tasks and expectations
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic pulse_in(input int s);
        @(posedge clk);
        {rfs_addressed, mw_take, mw_done} <= 3'b100 >> s;
        @(posedge clk);
        {rfs_addressed, mw_take, mw_done} <= 3'b000;
    endtask : pulse_in
    function automatic logic [1:0] dma_exp(input int free);
        if (free >= 4) return 2'b10;
        return (free > 0) ? 2'b01 : 2'b00;
    endfunction : dma_exp
    function automatic logic [31:0] st_exp(input logic [1:0] op,
        input logic [1:0] st, input logic [10:0] len);
        return {12'h0, len, 5'h0, st, op};
    endfunction : st_exp
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // ----------------
    // main sequence
    // ----------------
    initial begin
        logic [31:0] d, e;
        logic [7:0]  q[$];
        int          n;
        {reset, wr, rd, rfs_addressed, mw_take, mw_done} = 6'h20;
        {addr, wdata, num_errors, tests_run, cycles} = '0;
        last_seen = 1'b0;
        n = $urandom(61);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd_reg(itf_pkg::OFS_CTRL, d);
        chk(d, {24'h0, itf_pkg::TH_RST, 4'h0});
        rd_reg(itf_pkg::OFS_STATUS, d);
        chk(d, 32'h0);
        rd_reg(8'h1C, d);
        chk(d, 32'h0);
        rd_reg(itf_pkg::OFS_RAW, d);
        chk(d, 32'h8);
        // fill past full; the extra push is dropped
        for (int i = 0; i < 17; i++) begin
            d = $urandom;
            wr_reg(itf_pkg::OFS_TXDATA, d);
            if (i < 16) q.push_back(d[7:0]);
        end
        rd_reg(itf_pkg::OFS_LEVEL, d);
        chk(d, 32'h10);
        wr_reg(itf_pkg::OFS_CLR, 32'h8);
        rd_reg(itf_pkg::OFS_RAW, d);
        chk(d, 32'h0);
        // master write drain with dma, burst of four
        wr_reg(itf_pkg::OFS_CTRL, 32'h143);
        for (int i = 0; i < 16; i++) begin
            repeat (2) @(posedge clk);
            #1 chk(mw_go, 1'b1);
            chk(mw_byte, q[i]);
            chk({dma_burst_req, dma_single_req}, dma_exp(i));
            pulse_in(1);
        end
        pulse_in(2);
        rd_reg(itf_pkg::OFS_STATUS, d);
        chk(d, st_exp(itf_pkg::OP_MW, 2'h2, 11'd16));
        // master write may not start on an empty fifo
        wr_reg(itf_pkg::OFS_CTRL, 32'h143);
        repeat (2) @(posedge clk);
        #1 chk(mw_go, 1'b0);
        d = $urandom;
        wr_reg(itf_pkg::OFS_TXDATA, d);
        rd_reg(itf_pkg::OFS_TXDATA, e);
        chk(e[7:0], d[7:0]);
        chk(mw_go, 1'b1);
        pulse_in(1);
        pulse_in(2);
        // slave read: stale bytes flushed, request raised
        wr_reg(itf_pkg::OFS_CTRL, 32'h43);
        wr_reg(itf_pkg::OFS_TXDATA, $urandom);
        i_m.hold();
        pulse_in(0);
        @(posedge clk);
        #1 chk(scl_oe, 1'b1);
        rd_reg(itf_pkg::OFS_LEVEL, d);
        chk(d, 32'h0);
        wr_reg(itf_pkg::OFS_EN, 32'h1);
        #1 chk(irq, 1'b1);
        wr_reg(itf_pkg::OFS_CLR, 32'h1);
        wr_reg(itf_pkg::OFS_EN, 32'h0);
        #1 chk(irq, 1'b0);
        q.delete();
        fork
            i_m.read_frame(3, $urandom_range(7));
            for (int i = 0; i < 3; i++) begin
                for (n = 0; i == 2 && d[1] !== 1'b1 && n < 500; n++)
                    rd_reg(itf_pkg::OFS_RAW, d);
                d = $urandom & 32'hFD;
                wr_reg(itf_pkg::OFS_TXDATA, d);
                q.push_back(d[7:0]);
            end
        join
        for (int i = 0; i < 3; i++) chk(i_m.got_q[i], q[i]);
        rd_reg(itf_pkg::OFS_STATUS, d);
        chk(d, st_exp(itf_pkg::OP_RFS, 2'h2, 11'd3));
        rd_reg(itf_pkg::OFS_RAW, d);
        chk(d[2:1], 2'b11);
        chk(last_seen, 1'b1);
        test_done;
    end
endmodule : itf_tx_feed_bench

`default_nettype wire
